// File: rtl/osc_ctrl_defs.vh
// Constants for the internal oscillator clock control block.
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH
`define OSC_CTRL_ADDR 8'hB2
`define OSC_CAL_ADDR 8'hB3
`define OSC_CTRL_RESET 8'h80
`define OSC_EN_BIT 7
`define OSC_RDY_BIT 6
`define OSC_SUSP_BIT 5
`define OSC_DIV_MSB 1
`define OSC_DIV_LSB 0
`define OSC_CAL_MSB 4
`define OSC_CAL_LSB 0
`define DIV_BY_8 2'b00
`define DIV_BY_4 2'b01
`define DIV_BY_2 2'b10
`define DIV_BY_1 2'b11
`define CLK_SRC_INT 2'b00
`define CLK_SRC_EXT 2'b01
`define CLK_SRC_MUL 2'b10
`define OSC_SETTLE_NS 64
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + 3) / 4)
`endif

// File: rtl/osc_divider.v
// Post-divider that makes an enable pulse every 1, 2, 4 or 8 oscillator ticks.
`timescale 1ns/1ns
`include "osc_ctrl_defs.vh"
module osc_divider (
  input wire sys_clk,
  input wire rst,
  input wire run,
  input wire [1:0] div_sel,
  output reg tick_q
);
  reg [2:0] cnt_q;
  reg [2:0] last;

  always @* begin
    case (div_sel)
      `DIV_BY_8: last = 3'd7;
      `DIV_BY_4: last = 3'd3;
      `DIV_BY_2: last = 3'd1;
      default: last = 3'd0;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 3'd0;
      tick_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 3'd0;
      tick_q <= 1'b0;
    end else if (cnt_q >= last) begin
      cnt_q <= 3'd0;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 3'd1;
      tick_q <= 1'b0;
    end
  end
endmodule // osc_divider

// File: rtl/internal_osc_clock_ctrl.v
// Internal oscillator control register, suspend/wake logic and clock selection.
//
// Overview of operation
// - After any reset the core clock comes from the internal oscillator; here it follows core_clk_src, which reset does not set.
// - Core clock selects internal, external, or 4x multiplier divided by two.
// - USB function clock selects internal, external, or undivided 4x multiplier.
// - Each calibration step lengthens the oscillator period by about 0.0025 base periods.
// - Calibration reset value is the factory trim giving 12 MHz.
// - Internal oscillator divided by 1, 2, 4 or 8; divide-by-8 after reset.
// - Every reset restores the factory calibration value.
// - Writing one to the force-suspend bit stops the oscillator.
// - Non-idle USB bus activity restarts a stopped oscillator.
// - Supply sense matching the polarity select also restarts the oscillator.
// - The transceiver detects bus activity while suspended, oscillator stopped.
// - Wake by bus activity raises a resume interrupt.
// - Calibration is a 5-bit field in bits 4 to 0.
// - Calibration reads undefined while clock recovery is enabled.
`timescale 1ns/1ns
`include "osc_ctrl_defs.vh"
module internal_osc_clock_ctrl #(
  parameter [4:0] FACTORY_CAL = 5'h10
) (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata_q,
  input wire usb_nonidle,
  input wire vbus_level,
  input wire supply_polarity_select,
  input wire clock_recovery_en,
  input wire [1:0] core_clk_src,
  input wire [1:0] usb_clk_src,
  input wire ext_osc_tick,
  input wire mul4_tick,
  output reg core_clock_tick_q,
  output reg usb_function_clock_tick_q,
  output reg osc_running_q,
  output reg resume_irq_q,
  output wire [4:0] osc_calibration_value
);
  localparam ST_RUN = 4'b0001;
  localparam ST_SUSP = 4'b0010;
  localparam ST_SETTLE = 4'b0100;
  localparam ST_OFF = 4'b1000;

  reg [3:0] state_q;
  reg osc_enable_bit_q;
  reg [1:0] osc_divider_select_q;
  reg [4:0] osc_calibration_field_q;
  reg [7:0] settle_q;
  reg [2:0] usb_sync_q;
  reg [2:0] vbus_sync_q;
  reg mul_half_q;
  reg [7:0] rdata_d;
  wire osc_tick;
  wire int_div_tick;
  wire usb_wake;
  wire vbus_wake;
  wire ctrl_wr;
  wire osc_freq_ready_flag;

  assign ctrl_wr = sfr_wr && (sfr_addr == `OSC_CTRL_ADDR);
  // Wake pins arrive asynchronously; a change counts once stages two and three agree.
  assign usb_wake = usb_sync_q[1] && usb_sync_q[2];
  assign vbus_wake = (vbus_sync_q[1] == supply_polarity_select) &&
                     (vbus_sync_q[2] == supply_polarity_select);
  assign osc_tick = osc_running_q;
  assign osc_freq_ready_flag = (state_q == ST_RUN) && osc_enable_bit_q;
  assign osc_calibration_value = osc_calibration_field_q;

  osc_divider u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(osc_tick),
    .div_sel(osc_divider_select_q),
    .tick_q(int_div_tick)
  );

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      usb_sync_q <= 3'b000;
      vbus_sync_q <= 3'b000;
    end else begin
      usb_sync_q <= {usb_sync_q[1:0], usb_nonidle};
      vbus_sync_q <= {vbus_sync_q[1:0], vbus_level};
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      osc_enable_bit_q <= 1'b1;
      osc_divider_select_q <= `DIV_BY_8;
      osc_calibration_field_q <= FACTORY_CAL;
    end else if (sfr_wr) begin
      // Bit 5 is a command rather than stored state: the state machine decodes it from
      // the write data, so it always reads back as zero.
      if (sfr_addr == `OSC_CTRL_ADDR) begin
        osc_enable_bit_q <= sfr_wdata[`OSC_EN_BIT];
        osc_divider_select_q <= sfr_wdata[`OSC_DIV_MSB:`OSC_DIV_LSB];
      end else if (sfr_addr == `OSC_CAL_ADDR) begin
        osc_calibration_field_q <= sfr_wdata[`OSC_CAL_MSB:`OSC_CAL_LSB];
      end
    end
  end

  // After a wake or a re-enable the oscillator runs a short settling time before it
  // reports ready, so software never sees ready while the frequency is still moving.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
      settle_q <= 8'h00;
      resume_irq_q <= 1'b0;
      osc_running_q <= 1'b1;
    end else begin
      resume_irq_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          osc_running_q <= osc_enable_bit_q;
          if (ctrl_wr && sfr_wdata[`OSC_SUSP_BIT]) begin
            state_q <= ST_SUSP;
            osc_running_q <= 1'b0;
          end else if (!osc_enable_bit_q) begin
            // A disabled oscillator must settle again before ready is reported.
            state_q <= ST_OFF;
          end
        end
        ST_OFF: begin
          osc_running_q <= 1'b0;
          if (ctrl_wr && sfr_wdata[`OSC_SUSP_BIT]) begin
            state_q <= ST_SUSP;
          end else if (osc_enable_bit_q) begin
            state_q <= ST_SETTLE;
            settle_q <= 8'h00;
            osc_running_q <= 1'b1;
          end
        end
        ST_SUSP: begin
          // The transceiver keeps watching the bus while the oscillator is stopped, so
          // the wake path below runs on the synchronised pins alone.
          osc_running_q <= 1'b0;
          if (usb_wake || vbus_wake) begin
            state_q <= ST_SETTLE;
            resume_irq_q <= usb_wake;
            settle_q <= 8'h00;
            osc_running_q <= osc_enable_bit_q;
          end
        end
        ST_SETTLE: begin
          osc_running_q <= osc_enable_bit_q;
          settle_q <= settle_q + 8'h01;
          if (ctrl_wr && sfr_wdata[`OSC_SUSP_BIT]) begin
            state_q <= ST_SUSP;
            osc_running_q <= 1'b0;
          end else if (!osc_enable_bit_q) begin
            state_q <= ST_OFF;
          end else if (settle_q >= (`OSC_SETTLE_CYC - 1)) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Clock source selection is expressed as tick enables of the chosen source.
  // Retuning the calibration leaves the internal source unfit for USB; choosing another
  // USB source then is up to software, so no lock is placed on the selection here.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mul_half_q <= 1'b0;
      core_clock_tick_q <= 1'b0;
      usb_function_clock_tick_q <= 1'b0;
    end else begin
      if (mul4_tick) begin
        mul_half_q <= ~mul_half_q;
      end
      case (core_clk_src)
        `CLK_SRC_INT: core_clock_tick_q <= int_div_tick;
        `CLK_SRC_EXT: core_clock_tick_q <= ext_osc_tick;
        `CLK_SRC_MUL: core_clock_tick_q <= mul4_tick && mul_half_q;
        default: core_clock_tick_q <= int_div_tick;
      endcase
      case (usb_clk_src)
        `CLK_SRC_INT: usb_function_clock_tick_q <= osc_tick;
        `CLK_SRC_EXT: usb_function_clock_tick_q <= ext_osc_tick;
        `CLK_SRC_MUL: usb_function_clock_tick_q <= mul4_tick;
        default: usb_function_clock_tick_q <= osc_tick;
      endcase
    end
  end

  always @* begin
    rdata_d = 8'h00;
    if (sfr_addr == `OSC_CTRL_ADDR) begin
      rdata_d[`OSC_EN_BIT] = osc_enable_bit_q;
      rdata_d[`OSC_RDY_BIT] = osc_freq_ready_flag;
      rdata_d[`OSC_DIV_MSB:`OSC_DIV_LSB] = osc_divider_select_q;
    end else if (sfr_addr == `OSC_CAL_ADDR) begin
      // Under clock recovery the field is undefined; it reads as zero here.
      rdata_d[`OSC_CAL_MSB:`OSC_CAL_LSB] = clock_recovery_en ? 5'h00 :
                                           osc_calibration_field_q;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      sfr_rdata_q <= rdata_d;
    end
  end
endmodule // internal_osc_clock_ctrl

// File: test/osc_ctrl_sva.sv
// Assertion checker for the oscillator control block.
`timescale 1ns/1ns
module osc_ctrl_sva #(parameter [4:0] FACTORY_CAL = 5'h10) (
  input wire sys_clk,
  input wire rst,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_rdata_q,
  input wire usb_nonidle,
  input wire vbus_level,
  input wire supply_polarity_select,
  input wire osc_running_q,
  input wire resume_irq_q,
  input wire [4:0] osc_calibration_value
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence s_susp_wr;
    sfr_wr && sfr_addr == 8'hB2 && sfr_wdata[7] && sfr_wdata[5] && osc_running_q;
  endsequence
  sequence s_usb_stop;
    (!osc_running_q && usb_nonidle) [*3];
  endsequence
  sequence s_vbus_stop;
    (!osc_running_q && vbus_level == supply_polarity_select) [*3];
  endsequence
  property p_cal_rst;
    $past(rst) |-> osc_calibration_value == FACTORY_CAL;
  endproperty
  property p_run_rst;
    $past(rst) |-> osc_running_q;
  endproperty
  property p_susp;
    s_susp_wr |=> !osc_running_q;
  endproperty
  property p_usb_wake;
    s_usb_stop |-> ##[0:3] osc_running_q;
  endproperty
  property p_vbus_wake;
    s_vbus_stop |-> ##[0:3] osc_running_q;
  endproperty
  property p_irq_cause;
    resume_irq_q |-> osc_running_q && !$past(osc_running_q);
  endproperty
  property p_irq_pulse;
    resume_irq_q |=> !resume_irq_q;
  endproperty
  property p_cal_wr;
    sfr_wr && sfr_addr == 8'hB3 |=> osc_calibration_value == $past(sfr_wdata[4:0]);
  endproperty
  property p_unmapped;
    sfr_rd && sfr_addr != 8'hB2 && sfr_addr != 8'hB3 |=> sfr_rdata_q == 8'h00;
  endproperty
  a_cal_rst: assert property (p_cal_rst) else $error("cal not factory");
  a_run_rst: assert property (p_run_rst) else $error("osc idle at reset");
  a_susp: assert property (p_susp) else $error("no stop");
  a_usb_wake: assert property (p_usb_wake) else $error("no usb wake");
  a_vbus_wake: assert property (p_vbus_wake) else $error("no vbus wake");
  a_irq_cause: assert property (p_irq_cause) else $error("stray irq");
  a_irq_pulse: assert property (p_irq_pulse) else $error("long irq");
  a_cal_wr: assert property (p_cal_wr) else $error("cal lost");
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
endmodule // osc_ctrl_sva
bind internal_osc_clock_ctrl osc_ctrl_sva #(.FACTORY_CAL(FACTORY_CAL)) chk_u (
  .sys_clk, .rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata_q, .usb_nonidle,
  .vbus_level, .supply_polarity_select, .osc_running_q, .resume_irq_q, .osc_calibration_value
);

// File: test/tb_internal_osc_clock_ctrl.sv
// Self-checking bench for the oscillator control block.
`timescale 1ns/1ns
module tb_internal_osc_clock_ctrl;
  reg sys_clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0, usb_nonidle = 1'b0;
  reg vbus_level = 1'b1, supply_polarity_select = 1'b0, clock_recovery_en = 1'b0;
  reg ext_osc_tick = 1'b0, mul4_tick = 1'b0, h, hb = 1'b0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, v, n;
  reg [1:0] core_clk_src = 2'b00, usb_clk_src = 2'b00, e;
  reg [4:0] c;
  wire [7:0] rdata;
  wire core_tick, usb_tick, running, irq;
  wire [4:0] cal;
  integer err_total = 0, cmp_count = 0, cyc = 0, i, r;
  internal_osc_clock_ctrl #(.FACTORY_CAL(5'h10)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_rdata_q(rdata), .usb_nonidle(usb_nonidle), .vbus_level(vbus_level),
    .supply_polarity_select(supply_polarity_select), .clock_recovery_en(clock_recovery_en),
    .core_clk_src(core_clk_src), .usb_clk_src(usb_clk_src), .ext_osc_tick(ext_osc_tick),
    .mul4_tick(mul4_tick), .core_clock_tick_q(core_tick), .usb_function_clock_tick_q(usb_tick),
    .osc_running_q(running), .resume_irq_q(irq), .osc_calibration_value(cal));
  always #2 sys_clk = ~sys_clk;
  // Own model of the halving of the multiplier ticks.
  always @(posedge sys_clk) begin
    if (rst)
      hb <= 1'b0;
    else if (mul4_tick)
      hb <= ~hb;
  end
  task conclude;
    begin
      if (err_total == 0 && cmp_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    {ext_osc_tick, mul4_tick} <= 2'($urandom);
    cyc = cyc + 1;
    if (cyc == 8000) begin
      err_total = err_total + 1;
      conclude;
    end
  end
  task check(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge sys_clk) sfr_wr <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge sys_clk) sfr_rd <= 1'b0;
      @(posedge sys_clk) d = rdata;
    end
  endtask
  // Counts core ticks over 64 cycles, or notes a resume pulse over 8.
  task cnt(input integer len, output [7:0] t);
    begin
      t = 0;
      h = 0;
      repeat (len) begin
        @(negedge sys_clk);
        t = t + (core_tick === 1'b1);
        h = h | (irq === 1'b1);
      end
      @(posedge sys_clk);
    end
  endtask
  function [7:0] ticks_exp(input [1:0] dv);
    ticks_exp = 8'd64 >> (2'd3 - dv);
  endfunction
  initial begin
    r = $urandom(32'h2702_34da);
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (24) @(posedge sys_clk);
    rd(8'hB2, v);
    check(v, 8'hC0);
    for (i = 0; i < 4; i = i + 1) begin
      if (i > 0) wr(8'hB2, {6'h20, i[1:0]});
      repeat (20) @(posedge sys_clk);
      cnt(64, n);
      check(n, ticks_exp(i[1:0]));
    end
    repeat (8) begin
      c = 5'($urandom % 32);
      wr(8'hB3, {3'b111, c});
      rd(8'hB3, v);
      check(v, {3'b000, c});
      check({3'b000, cal}, {3'b000, c});
    end
    n = 8'($urandom);
    if (n == 8'hB2 || n == 8'hB3) n = 8'h00;
    wr(n, 8'hFF);
    rd(n, v);
    check(v, 8'h00);
    check({3'b000, cal}, {3'b000, c});
    clock_recovery_en <= 1'b1;
    rd(8'hB3, v);
    check(v, 8'h00);
    clock_recovery_en <= 1'b0;
    core_clk_src <= 2'b01;
    usb_clk_src <= 2'b10;
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge sys_clk);
      if (i == 32) begin
        core_clk_src <= 2'b10;
        usb_clk_src <= 2'b01;
      end
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      e = (i < 32) ? {ext_osc_tick, mul4_tick} : {mul4_tick && hb, ext_osc_tick};
      @(negedge sys_clk);
      check({7'd0, core_tick}, {7'd0, e[1]});
      check({7'd0, usb_tick}, {7'd0, e[0]});
    end
    @(posedge sys_clk);
    core_clk_src <= 2'b00;
    usb_clk_src <= 2'b00;
    for (i = 0; i < 2; i = i + 1) begin
      repeat (24) @(posedge sys_clk);
      rd(8'hB2, v);
      check(v, 8'hC3);
      wr(8'hB2, 8'hA3);
      check({7'd0, running}, 8'h00);
      rd(8'hB2, v);
      check(v, 8'h83);
      if (i == 0) usb_nonidle <= 1'b1;
      else supply_polarity_select <= 1'b1;
      cnt(8, n);
      check({7'd0, h}, {7'd0, i == 0});
      check({7'd0, running}, 8'h01);
      usb_nonidle <= 1'b0;
      supply_polarity_select <= 1'b0;
    end
    repeat (24) @(posedge sys_clk);
    wr(8'hB2, 8'h03);
    @(posedge sys_clk);
    check({7'd0, running}, 8'h00);
    rd(8'hB2, v);
    check(v, 8'h03);
    wr(8'hB2, 8'h83);
    repeat (24) @(posedge sys_clk);
    check({7'd0, running}, 8'h01);
    rd(8'hB2, v);
    check(v, 8'hC3);
    rst <= 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (24) @(posedge sys_clk);
    rd(8'hB3, v);
    check(v, 8'h10);
    check({3'b000, cal}, 8'h10);
    rd(8'hB2, v);
    check(v, 8'hC0);
    conclude;
  end
endmodule // tb_internal_osc_clock_ctrl
